// [sacd_decode.sv]
// Setup and calibration decode: setup pairs, per-channel calibration
// registers, command execution with settle delay, output scaling.
// Assumes the serial port delivers decoded word writes and reads.
`timescale 1ns/1ps
`default_nettype none
module sacd_decode (
	input wire logic mclk_in, // Master clock
	input wire logic rst_in, // Sync reset, high
	input wire sacd_pkg::sacd_req_type req_in, // Register access
	output logic [31:0] rdata_out, // Read data
	input wire logic cmd_go_in, // Execute a setup
	input wire logic [2:0] cmd_setup_in, // Setup number less one
	input wire logic cmd_single_in, // Single conversion
	input wire logic cmd_stop_in, // Stop conversions
	input wire logic signed [23:0] raw_in, // Filter word
	input wire logic raw_valid_in, // Filter word strobe
	output logic [31:0] word_out, // Corrected word
	output logic word_valid_out, // Corrected strobe
	output logic conv_start_out, // Modulator start pulse
	output logic busy_out, // Settling or running
	output logic first_conv_out, // Longer first conversion
	output logic [6:0] amp_gain_out, // One-hot gain 1..64
	output logic [15:0] word_period_out, // Period in clocks
	output logic rate_bad_out, // Unused rate code
	output logic unipolar_out, // Unipolar coding
	output logic aux_out_zero, // Aux latch output 0
	output logic aux_out_one, // Aux latch output 1
	output logic [3:0] probe_en_out, // Probe per input
	output logic [1:0] channel_out, // Physical channel
	output logic [1:0] cal_idx_out // Cal register set
);
	import sacd_pkg::*;

	// ========================================================
	// Registers
	logic [31:0] setup_pair_q [SACD_PAIRS];
	logic [31:0] offset_q [SACD_CH];
	logic [31:0] gain_q [SACD_CH];
	logic [31:0] config_q;
	logic [31:0] pair_word;
	sacd_setup_type cur;
	logic latch_source_select, cal_set_mode, notch_rate_select;

	assign latch_source_select = config_q[SACD_CFG_OLS];
	assign cal_set_mode = config_q[SACD_CFG_OGS];
	assign notch_rate_select = config_q[SACD_CFG_FRS];

	// Setup pair writes, both halves at once
	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < SACD_PAIRS; i++) begin
			if (rst_in) begin
				setup_pair_q[i] <= '0;
			end else if (req_in.wr && req_in.kind == SACD_K_SETUP &&
					req_in.idx == 2'(i)) begin
				setup_pair_q[i] <= req_in.wdata;
			end
		end
	end

	// Calibration registers, one pair per channel
	generate
		for (genvar c = 0; c < SACD_CH; c++) begin : g_cal
			always_ff @(posedge mclk_in) begin
				if (rst_in) begin
					gain_q[c] <= SACD_GAIN_RST;
					offset_q[c] <= SACD_OFS_RST;
				end else if (req_in.wr && req_in.idx == 2'(c)) begin
					if (req_in.kind == SACD_K_GAIN) begin
						gain_q[c] <= req_in.wdata & SACD_GAIN_MASK;
					end
					if (req_in.kind == SACD_K_OFFSET) begin
						offset_q[c] <= req_in.wdata & SACD_OFS_MASK;
					end
				end
			end
		end
	endgenerate

	// Configuration bits that steer this block
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			config_q <= '0;
		end else if (req_in.wr && req_in.kind == SACD_K_CONFIG) begin
			config_q <= req_in.wdata & SACD_CFG_MASK;
		end
	end

	// Read data
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else if (req_in.rd) begin
			case (req_in.kind)
				SACD_K_SETUP: rdata_out <= setup_pair_q[req_in.idx];
				SACD_K_OFFSET: rdata_out <= offset_q[req_in.idx];
				SACD_K_GAIN: rdata_out <= gain_q[req_in.idx];
				default: rdata_out <= config_q;
			endcase
		end
	end

	// ========================================================
	// Setup selection: odd setups (even cmd_setup_in) in the upper half
	assign pair_word = setup_pair_q[cmd_setup_in[2:1]];
	assign cur = cmd_setup_in[0] ?
		sacd_setup_type'(pair_word[15:0]) :
		sacd_setup_type'(pair_word[31:SACD_UPPER_LSB]);

	// ========================================================
	// Sequencer
	typedef enum logic [1:0] {
		SACD_IDLE = 2'b00,
		SACD_SETTLE = 2'b01,
		SACD_RUN = 2'b10
	} sacd_state_type;
	sacd_state_type state_q;
	logic [15:0] settle_q;
	logic single_q;
	logic go_ok;

	assign go_ok = cmd_go_in && state_q == SACD_IDLE;
	assign busy_out = state_q != SACD_IDLE;

	// State and settle counter
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q <= SACD_IDLE;
			settle_q <= '0;
		end else begin
			case (state_q)
				SACD_IDLE: begin
					if (go_ok && cur.settle_delay_enable) begin
						state_q <= SACD_SETTLE;
						settle_q <= (notch_rate_select ? SACD_SETTLE_50 :
							SACD_SETTLE_60) - 16'd1;
					end else if (go_ok) begin
						state_q <= SACD_RUN;
					end
				end
				SACD_SETTLE: begin
					if (cmd_stop_in) begin
						state_q <= SACD_IDLE;
					end else if (settle_q == '0) begin
						state_q <= SACD_RUN;
					end else begin
						settle_q <= settle_q - 16'd1;
					end
				end
				SACD_RUN: begin
					if (cmd_stop_in || (single_q && raw_valid_in)) begin
						state_q <= SACD_IDLE;
					end
				end
				default: state_q <= SACD_IDLE;
			endcase
		end
	end

	// Start pulse on entry to run
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			conv_start_out <= 1'b0;
		end else begin
			conv_start_out <= state_q != SACD_RUN &&
				!cmd_stop_in && ((go_ok && !cur.settle_delay_enable) ||
				(state_q == SACD_SETTLE && settle_q == '0));
		end
	end

	// First conversion flag, cleared by first word unless single
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			first_conv_out <= 1'b0;
			single_q <= 1'b0;
		end else if (go_ok) begin
			first_conv_out <= 1'b1;
			single_q <= cmd_single_in;
		end else if (raw_valid_in && !single_q) begin
			first_conv_out <= 1'b0;
		end
	end

	// ========================================================
	// Setup field decode, latched when a command executes
	logic [3:0] rshift;
	assign rshift = cur.output_rate_code[3] ?
		{1'b0, cur.output_rate_code[2:0]} :
		SACD_SLOW_SHIFT + {1'b0, cur.output_rate_code[2:0]};

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			amp_gain_out <= 7'h01;
			word_period_out <= SACD_PERIOD_60;
			rate_bad_out <= 1'b0;
			unipolar_out <= 1'b0;
			probe_en_out <= '0;
			channel_out <= '0;
			cal_idx_out <= '0;
		end else if (go_ok) begin
			amp_gain_out <= (cur.amp_gain_code > SACD_GAIN_MAX) ? 7'h00 :
				7'h01 << cur.amp_gain_code;
			word_period_out <= (notch_rate_select ? SACD_PERIOD_50 :
				SACD_PERIOD_60) << rshift;
			rate_bad_out <= cur.output_rate_code[2:0] >
				SACD_RATE_STEPS;
			unipolar_out <= cur.unipolar;
			probe_en_out <= cur.open_input_probe ?
				4'h1 << cur.input_select_code : 4'h0;
			channel_out <= cur.input_select_code;
			cal_idx_out <= cal_set_mode ? cur.cal_set_pointer :
				cur.input_select_code;
		end
	end

	// Aux latch outputs
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			aux_out_zero <= 1'b0;
			aux_out_one <= 1'b0;
		end else if (latch_source_select) begin
			aux_out_zero <= config_q[SACD_CFG_AUX0];
			aux_out_one <= config_q[SACD_CFG_AUX1];
		end else if (go_ok) begin
			aux_out_zero <= cur.setup_latch_bits[1];
			aux_out_one <= cur.setup_latch_bits[0];
		end
	end

	// ========================================================
	// Output scaling: offset added, then sum scaled by gain
	logic signed [32:0] sum;
	logic signed [63:0] prod;
	logic [8:0] top;
	// Offset is signed and MSB aligned with the data word
	assign sum = $signed({raw_in[23], raw_in, 8'h00}) +
		$signed({offset_q[cal_idx_out][31],
		offset_q[cal_idx_out]});
	assign prod = 64'(sum) * $signed({32'h0,
		gain_q[cal_idx_out]});
	assign top = prod[63:55];

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			word_out <= '0;
			word_valid_out <= 1'b0;
		end else begin
			word_valid_out <= raw_valid_in;
			if (raw_valid_in) begin
				if (top == '0 || top == '1) begin
					word_out <= prod[SACD_GAIN_FRAC +: 32];
				end else begin
					word_out <= top[8] ? 32'h8000_0000 : 32'h7fff_ffff;
				end
			end
		end
	end

	// ========================================================
	// Assertions
	logic [15:0] settle_seen_q;
	logic was_settle_q;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			settle_seen_q <= '0;
			was_settle_q <= 1'b0;
		end else begin
			was_settle_q <= state_q == SACD_SETTLE;
			settle_seen_q <= state_q == SACD_SETTLE ?
				settle_seen_q + 16'd1 : '0;
		end
	end

	property p_gain_reset;
		@(posedge mclk_in) $fell(rst_in) |->
			gain_q[0] == SACD_GAIN_RST && offset_q[0] == '0;
	endproperty
	a_gain_reset: assert property (p_gain_reset)
		else $error("gain or offset not at reset value");

	property p_settle_len;
		@(posedge mclk_in) disable iff (rst_in)
		(was_settle_q && conv_start_out) |->
			$past(settle_seen_q) + 16'd1 ==
			(notch_rate_select ? SACD_SETTLE_50 : SACD_SETTLE_60);
	endproperty
	a_settle_len: assert property (p_settle_len)
		else $error("settle delay length wrong");

	property p_no_delay;
		@(posedge mclk_in) disable iff (rst_in)
		(go_ok && !cur.settle_delay_enable && !cmd_stop_in) |=>
			conv_start_out;
	endproperty
	a_no_delay: assert property (p_no_delay)
		else $error("immediate start missing");

	property p_aux_setup;
		@(posedge mclk_in) disable iff (rst_in)
		(go_ok && !latch_source_select) |=> aux_out_zero ==
			$past(cur.setup_latch_bits[1]) &&
			aux_out_one == $past(cur.setup_latch_bits[0]);
	endproperty
	a_aux_setup: assert property (p_aux_setup)
		else $error("aux outputs not from setup");

	property p_aux_cfg;
		@(posedge mclk_in) disable iff (rst_in)
		latch_source_select ##1 latch_source_select |-> aux_out_one == $past(config_q[SACD_CFG_AUX1]) &&
			aux_out_zero == $past(config_q[SACD_CFG_AUX0]);
	endproperty
	a_aux_cfg: assert property (p_aux_cfg)
		else $error("aux outputs not from config");

	property p_cal_idx;
		@(posedge mclk_in) disable iff (rst_in)
		go_ok |=> cal_idx_out == ($past(cal_set_mode) ?
			$past(cur.cal_set_pointer) : $past(cur.input_select_code));
	endproperty
	a_cal_idx: assert property (p_cal_idx)
		else $error("calibration set wrong");

	property p_probe;
		@(posedge mclk_in) disable iff (rst_in)
		go_ok |=> $countones(probe_en_out) ==
			($past(cur.open_input_probe) ? 1 : 0) &&
			(!$past(cur.open_input_probe) ||
			probe_en_out[$past(cur.input_select_code)]);
	endproperty
	a_probe: assert property (p_probe)
		else $error("probe enable wrong");

	property p_gain_code;
		@(posedge mclk_in) disable iff (rst_in)
		go_ok && cur.amp_gain_code <= SACD_GAIN_MAX |=>
			$onehot(amp_gain_out) &&
			amp_gain_out[$past(cur.amp_gain_code)];
	endproperty
	a_gain_code: assert property (p_gain_code)
		else $error("gain decode wrong");

	property p_unity;
		@(posedge mclk_in) disable iff (rst_in)
		(raw_valid_in && gain_q[cal_idx_out] == SACD_GAIN_RST &&
			offset_q[cal_idx_out] == '0) |=>
			word_valid_out && word_out == $past({raw_in, 8'h00});
	endproperty
	a_unity: assert property (p_unity)
		else $error("unity scaling wrong");

	c_settle: cover property (@(posedge mclk_in)
		was_settle_q && conv_start_out);
	c_single: cover property (@(posedge mclk_in)
		single_q && raw_valid_in && state_q == SACD_RUN);
	c_ogs: cover property (@(posedge mclk_in) go_ok && cal_set_mode);
endmodule : sacd_decode
`default_nettype wire

// [sacd_host.sv]
// Host model: register writes and reads on the decoder's register port.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module sacd_host (
	input wire logic mclk_in, // Master clock
	input wire logic [31:0] rdata_in, // Read data
	output var sacd_pkg::sacd_req_type req_out // Register access
);
	import sacd_pkg::*;
	localparam logic [31:0] GAIN_LIMIT = 32'h2800_0000;
	int idle = 0;
	initial req_out = '0;
	// ======================================
	// Idle cycles, then one whole-word access
	task automatic xfer(input logic w, input sacd_kind_type k,
		input logic [1:0] i, input logic [31:0] d,
		output logic [31:0] q);
		// Never program a gain above 40
		if (w && k == SACD_K_GAIN && (d & SACD_GAIN_MASK) > GAIN_LIMIT)
			d = (d & ~SACD_GAIN_MASK) | GAIN_LIMIT;
		repeat (idle) @(posedge mclk_in);
		@(posedge mclk_in);
		req_out <= '{w, !w, k, i, d};
		@(posedge mclk_in);
		req_out <= '0;
		@(posedge mclk_in);
		#1 q = rdata_in;
	endtask : xfer
endmodule : sacd_host
`default_nettype wire

// [sacd_pkg.sv]
// Package for the setup and calibration decode block: field layouts,
// register kinds, reset values and master-clock counts.
// Assumes one master clock and a host that writes whole 32-bit words.
//
// How it works
// - Gain code 0..6 selects gain 1..64
// - Rate code picks word rate; notch select scales 5/6
// - Word period counted in master clocks, scales
// - First or single conversion flagged as longer
// - Polarity bit: 0 bipolar, 1 unipolar
// - Source 0: setup latch bits drive aux outs
// - Settle bit waits 1280 or 1536 clocks
// - Probe bit enables source on chosen input
// - Pointer used only when cal set mode set
// - Pointer 0..3 picks channel 1..4 registers
// - Reset values give gain 1.0, offset 0.0
// - Separate offset and gain register per channel
// - Offset top bit is the sign
// - Offset step is fixed fraction of span
// - Offset applied then scaled through gain
// - Gain unsigned, bit i weighs 2^(i-24)
// - Gain resets to only bit 24 set
// - Setup pair: upper half odd setup, both together
// - Input select 0..3 picks channel 1..4
// - Source 1: config latch bits drive aux outs
package sacd_pkg;
	// ========================================================
	// Sizes
	localparam int SACD_CH = 4;
	localparam int SACD_PAIRS = 4;
	// ========================================================
	// Register kinds on the register port
	typedef enum logic [1:0] {
		SACD_K_SETUP = 2'b00,
		SACD_K_OFFSET = 2'b01,
		SACD_K_GAIN = 2'b10,
		SACD_K_CONFIG = 2'b11
	} sacd_kind_type;
	// ========================================================
	// One 16-bit setup, most significant field first
	typedef struct packed {
		logic [1:0] input_select_code;
		logic [2:0] amp_gain_code;
		logic [3:0] output_rate_code;
		logic unipolar;
		logic [1:0] setup_latch_bits;
		logic settle_delay_enable;
		logic open_input_probe;
		logic [1:0] cal_set_pointer;
	} sacd_setup_type;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		sacd_kind_type kind;
		logic [1:0] idx;
		logic [31:0] wdata;
	} sacd_req_type;
	// ========================================================
	// Field positions and reset values
	localparam int SACD_UPPER_LSB = 16;
	localparam int SACD_CFG_AUX1 = 24;
	localparam int SACD_CFG_AUX0 = 23;
	localparam int SACD_CFG_OLS = 22;
	localparam int SACD_CFG_OGS = 20;
	localparam int SACD_CFG_FRS = 19;
	localparam logic [31:0] SACD_CFG_MASK = 32'h01d8_0000;
	localparam logic [31:0] SACD_GAIN_RST = 32'h0100_0000;
	localparam logic [31:0] SACD_GAIN_MASK = 32'h3fff_ffff;
	localparam logic [31:0] SACD_OFS_RST = 32'h0000_0000;
	localparam logic [31:0] SACD_OFS_MASK = 32'hffff_ff00;
	localparam int SACD_GAIN_FRAC = 24;
	localparam logic [2:0] SACD_GAIN_MAX = 3'h6;
	localparam logic [2:0] SACD_RATE_STEPS = 3'h4;
	localparam logic [3:0] SACD_SLOW_SHIFT = 4'h5;
	// ========================================================
	// Master-clock counts: settle delay and fastest word period
	localparam logic [15:0] SACD_SETTLE_60 = 16'd1280;
	localparam logic [15:0] SACD_SETTLE_50 = 16'd1536;
	localparam logic [15:0] SACD_PERIOD_60 = 16'd1280;
	localparam logic [15:0] SACD_PERIOD_50 = 16'd1536;
endpackage : sacd_pkg

// [tb_top.sv]
// Bench: random setups and calibration values against a queue-free model.
// Assumes sacd_host drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sacd_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	sacd_req_type req;
	logic [31:0] rdata, word, q, e;
	logic go = 1'b0, single = 1'b0, stop = 1'b0, rawv = 1'b0;
	logic [2:0] setup = 3'h0;
	logic signed [23:0] raw = 24'h00_0000;
	logic wv, start, busy, first, rbad, unip, ax0, ax1;
	logic [6:0] gain_o;
	logic [15:0] per;
	logic [3:0] probe;
	logic [1:0] ch, cal, m_cal;
	int n_mismatch = 0, n_compared = 0, seed = 52, n;
	logic [31:0] m_pair [4], m_gain [4], m_ofs [4], m_cfg;
	// Master clock, 100 ns
	always #50 mclk_in = ~mclk_in;
	sacd_host host (.mclk_in(mclk_in), .rdata_in(rdata), .req_out(req));
	sacd_decode dut (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req),
		.rdata_out(rdata), .cmd_go_in(go), .cmd_setup_in(setup),
		.cmd_single_in(single), .cmd_stop_in(stop), .raw_in(raw),
		.raw_valid_in(rawv), .word_out(word), .word_valid_out(wv),
		.conv_start_out(start), .busy_out(busy), .first_conv_out(first),
		.amp_gain_out(gain_o), .word_period_out(per),
		.rate_bad_out(rbad), .unipolar_out(unip), .aux_out_zero(ax0),
		.aux_out_one(ax1), .probe_en_out(probe), .channel_out(ch),
		.cal_idx_out(cal));
	// ======================================
	// Compare and close
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	// Register write with model update, read with compare
	task automatic wreg(input sacd_kind_type k, input logic [1:0] i,
		input logic [31:0] d);
		host.xfer(1'b1, k, i, d, q);
		case (k)
			SACD_K_SETUP: m_pair[i] = d;
			SACD_K_OFFSET: m_ofs[i] = d & SACD_OFS_MASK;
			SACD_K_GAIN: m_gain[i] = d & SACD_GAIN_MASK;
			default: m_cfg = d & SACD_CFG_MASK;
		endcase
	endtask : wreg
	task automatic rchk(input sacd_kind_type k, input logic [1:0] i,
		input logic [31:0] x);
		host.xfer(1'b0, k, i, 32'h0000_0000, q);
		chk("register", q, x);
	endtask : rchk
	// ======================================
	// Stop, execute one setup, count to start, check decode
	task automatic run(input logic [2:0] s);
		sacd_setup_type u;
		int r;
		@(posedge mclk_in);
		stop <= 1'b1;
		@(posedge mclk_in);
		stop <= 1'b0;
		go <= 1'b1;
		setup <= s;
		@(posedge mclk_in);
		go <= 1'b0;
		n = 0;
		// Start pulse stands one cycle, from the go edge or from the end of the settle delay
		#1;
		while (!start && n < 2000) begin
			@(posedge mclk_in);
			#1 n++;
		end
		if (n >= 2000) begin
			n_mismatch++;
			stop_test();
		end
		u = s[0] ? m_pair[s[2:1]][15:0] : m_pair[s[2:1]][31:16];
		r = u.output_rate_code[2:0];
		e = u.settle_delay_enable ? (m_cfg[19] ? 1536 : 1280) : 0;
		chk("start delay", n, e);
		chk("busy", busy, 1'b1);
		e = u.amp_gain_code > 3'h6 ? 0 : 1 << u.amp_gain_code;
		chk("gain", gain_o, e);
		e = (m_cfg[19] ? 1536 : 1280) << (u.output_rate_code[3] ? r : r + 5);
		chk("period", per, e[15:0]);
		chk("rate bad", rbad, r > 4);
		chk("unipolar", unip, u.unipolar);
		e = m_cfg[22] ? m_cfg[23] : u.setup_latch_bits[1];
		chk("aux0", ax0, e);
		e = m_cfg[22] ? m_cfg[24] : u.setup_latch_bits[0];
		chk("aux1", ax1, e);
		e = u.open_input_probe ? 4'h1 << u.input_select_code : 4'h0;
		chk("probe", probe, e);
		chk("channel", ch, u.input_select_code);
		m_cal = m_cfg[20] ? u.cal_set_pointer : u.input_select_code;
		chk("cal set", cal, m_cal);
		chk("first", first, 1'b1);
	endtask : run
	// Feed one filter word and compare the corrected word
	task automatic feed(input logic signed [23:0] v);
		longint a;
		@(posedge mclk_in);
		raw <= v;
		rawv <= 1'b1;
		@(posedge mclk_in);
		rawv <= 1'b0;
		a = (longint'(v) <<< 8) + longint'($signed(m_ofs[m_cal]));
		a = (a * longint'(m_gain[m_cal])) >>> 24;
		if (a > 64'sh7fff_ffff)
			a = 64'sh7fff_ffff;
		if (a < -64'sh8000_0000)
			a = -64'sh8000_0000;
		// Valid stands for one cycle only, so look just after its edge
		#1 chk("valid", wv, 1'b1);
		chk("word", word, a[31:0]);
		chk("first after word", first, single);
		chk("busy after word", busy, !single);
	endtask : feed
	// ======================================
	// Main sequence
	initial begin
		for (int i = 0; i < 4; i++) begin
			m_pair[i] = 32'h0000_0000;
			m_gain[i] = SACD_GAIN_RST;
			m_ofs[i] = SACD_OFS_RST;
		end
		m_cfg = 32'h0000_0000;
		m_cal = 2'h0;
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		#1 chk("reset gain", gain_o, 7'h01);
		chk("reset period", per, 16'd1280);
		for (int i = 0; i < 4; i++) begin
			rchk(SACD_K_GAIN, i[1:0], SACD_GAIN_RST);
			rchk(SACD_K_OFFSET, i[1:0], SACD_OFS_RST);
		end
		run(3'h0);
		feed(24'sh12_3456);
		$display("Reset test done");
		for (int i = 0; i < 4; i++) begin
			wreg(SACD_K_GAIN, i[1:0], ($random(seed) & 32'h1fff_ffff) | 32'hc000_0000);
			wreg(SACD_K_OFFSET, i[1:0], $random(seed));
		end
		for (int i = 0; i < 4; i++) begin
			rchk(SACD_K_GAIN, i[1:0], m_gain[i]);
			rchk(SACD_K_OFFSET, i[1:0], m_ofs[i]);
		end
		$display("Calibration register test done");
		for (int k = 0; k < 32; k++) begin
			host.idle = k % 3;
			e = $random(seed);
			e[29:27] = k[2:0];
			e[26:23] = k[3:0];
			wreg(SACD_K_SETUP, k[1:0], e);
			wreg(SACD_K_CONFIG, 2'h0, $random(seed));
			rchk(SACD_K_CONFIG, 2'h0, m_cfg);
			rchk(SACD_K_SETUP, k[1:0], m_pair[k[1:0]]);
			single <= k[4];
			run({k[1:0], 1'b0});
			feed($random(seed));
			run({k[1:0], 1'b1});
			feed($random(seed));
		end
		$display("Setup decode test done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
